// ---- hw/pdmr_pkg.sv ----
// Contract
// - writing one to the start bit of interrupt_disable clears its enable; read shows enable.
// - writing one to the halt bit of interrupt_disable clears its enable; read shows enable.
// - writing one to the end bit of interrupt_disable clears its enable; read shows enable.
// - left gain steps half a decibel, code 0x00 is -20 dB, 0x50 +20 dB.
// - left gain code 0x28 is unity, and the register resets to it.
// - a separate right gain register scales the right output channel.
// - decimation ratio picks mic clocks per sample; software retunes the clock setting.
// - default clock setting gives about 1.032 MHz, the 1280K setting 1.280 MHz; at 20 MHz the code gives 1.000 and 1.250 MHz.
// - the mode register routes the microphone data onto the left and right channels.
// - the sample pointer holds the RAM address where samples are written.
// - the sample count holds how many samples one buffer transfer holds.
// - the end event rises after the last counted sample, or the last after stop.
package pdmr_pkg;
  localparam logic [11:0] OFS_TASK_START  = 12'h000;
  localparam logic [11:0] OFS_TASK_STOP   = 12'h004;
  localparam logic [11:0] OFS_INTEN_SET   = 12'h304;
  localparam logic [11:0] OFS_INTEN_CLR   = 12'h308;
  localparam logic [11:0] OFS_EV_STATUS   = 12'h30c;
  localparam logic [11:0] OFS_ENABLE      = 12'h500;
  localparam logic [11:0] OFS_CLKCTRL     = 12'h504;
  localparam logic [11:0] OFS_MODE        = 12'h508;
  localparam logic [11:0] OFS_GAIN_L      = 12'h518;
  localparam logic [11:0] OFS_GAIN_R      = 12'h51c;
  localparam logic [11:0] OFS_RATIO       = 12'h520;
  localparam logic [11:0] OFS_PSEL_CLK    = 12'h540;
  localparam logic [11:0] OFS_PSEL_DIN    = 12'h544;
  localparam logic [11:0] OFS_MCLKCFG     = 12'h54c;
  localparam logic [11:0] OFS_SMP_PTR     = 12'h560;
  localparam logic [11:0] OFS_SMP_CNT     = 12'h564;
  // event bit positions in enable, disable and status registers
  localparam int          EV_STARTED      = 0;
  localparam int          EV_HALTED       = 1;
  localparam int          EV_DONE         = 2;
  localparam int          PSEL_DISC_BIT   = 31;
  localparam logic [31:0] PSEL_RESET      = 32'h8000_0000;
  localparam logic [6:0]  GAIN_MIN        = 7'h00;
  localparam logic [6:0]  GAIN_UNITY      = 7'h28;
  localparam logic [6:0]  GAIN_MAX        = 7'h50;
  localparam logic [6:0]  GAIN_OCT_BIAS   = 7'h08;
  localparam logic [6:0]  STEPS_PER_OCT   = 7'h0c;
  localparam logic [3:0]  GAIN_SHIFT_BASE = 4'hc;
  localparam logic [6:0]  RATIO_64        = 7'h40;
  localparam logic [6:0]  RATIO_80        = 7'h50;
  localparam int          PCM_SHIFT       = 9;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          MIC_HZ_DEFAULT  = 1_032_000;
  localparam int          MIC_HZ_1280K    = 1_280_000;
  localparam logic [4:0]  HALF_DEFAULT    = 5'((CLK_HZ + MIC_HZ_DEFAULT) / (2 * MIC_HZ_DEFAULT));
  localparam logic [4:0]  HALF_1280K      = 5'((CLK_HZ + MIC_HZ_1280K) / (2 * MIC_HZ_1280K));
  localparam logic [15:0] CNT_RESET       = 16'h0000;
  localparam logic [31:0] PTR_RESET       = 32'h0000_0000;
  typedef enum logic { CLK_SEL_DEFAULT, CLK_SEL_1280K } pdmr_clksel_t;
  typedef enum logic { RATIO_SEL_64, RATIO_SEL_80 } pdmr_ratio_t;
  typedef enum logic { MODE_STEREO, MODE_MONO } pdmr_mode_t;
endpackage : pdmr_pkg

// ---- hw/pdmr_top.sv ----
// Chosen here: register access over Avalon-MM.
module pdmr_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic [11:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output logic             IRQ_O,
  output logic             MIC_CLK_O,
  output logic             MIC_CLK_OE_O,
  input  wire logic        MIC_DATA_I,
  output logic             DMA_VALID_O,
  output logic      [31:0] DMA_ADDR_O,
  output logic      [31:0] DMA_DATA_O,
  input  wire logic        DMA_READY_I
);
  import pdmr_pkg::*;

  typedef enum logic [1:0] { ST_IDLE, ST_RUN, ST_STOPPING } pdmr_state_t;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // half-decibel gain: 2^(1/12) mantissa per step, octave by shift
  function automatic logic signed [15:0] gain_apply(input logic signed [15:0] x, input logic [6:0] code);
    logic        [6:0]  u;
    logic        [8:0]  m;
    logic        [3:0]  sh;
    logic signed [26:0] p;
    logic signed [26:0] s;
    u  = code + GAIN_OCT_BIAS;
    sh = GAIN_SHIFT_BASE - 4'(u / STEPS_PER_OCT);
    case (u % STEPS_PER_OCT)
      7'h00:   m = 9'h100;
      7'h01:   m = 9'h10f;
      7'h02:   m = 9'h11f;
      7'h03:   m = 9'h130;
      7'h04:   m = 9'h143;
      7'h05:   m = 9'h156;
      7'h06:   m = 9'h16a;
      7'h07:   m = 9'h180;
      7'h08:   m = 9'h196;
      7'h09:   m = 9'h1af;
      7'h0a:   m = 9'h1c8;
      default: m = 9'h1e3;
    endcase
    p = 27'(x) * 27'($signed({1'b0, m}));
    s = p >>> sh;
    if (s > 27'sh0007fff) begin
      return 16'sh7fff;
    end else if (s < -27'sh0008000) begin
      return -16'sh8000;
    end
    return s[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave
  logic        ack_q;
  logic        wr_take;
  logic        rd_take;
  logic [31:0] rd_mux;
  logic [31:0] readdata_q;
  logic [2:0]  inten_q;
  logic [2:0]  status_q;
  logic [2:0]  ev_pulse;
  logic        enable_q;
  logic        clksel_q;
  logic        mode_q;
  logic [6:0]  gain_l_q;
  logic [6:0]  gain_r_q;
  logic        ratio_q;
  logic [31:0] psel_clk_q;
  logic [31:0] psel_din_q;
  logic [31:0] mclkcfg_q;
  logic [31:0] smp_ptr_q;
  logic [15:0] smp_cnt_q;

  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign wr_take           = AVS_WRITE_I & ack_q;
  assign rd_take           = AVS_READ_I & ack_q;
  assign AVS_READDATA_O    = readdata_q;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      OFS_INTEN_SET, OFS_INTEN_CLR: rd_mux[2:0] = inten_q;
      OFS_EV_STATUS:                rd_mux[2:0] = status_q;
      OFS_ENABLE:                   rd_mux[0]   = enable_q;
      OFS_CLKCTRL:                  rd_mux[0]   = clksel_q;
      OFS_MODE:                     rd_mux[0]   = mode_q;
      OFS_GAIN_L:                   rd_mux[6:0] = gain_l_q;
      OFS_GAIN_R:                   rd_mux[6:0] = gain_r_q;
      OFS_RATIO:                    rd_mux[0]   = ratio_q;
      OFS_PSEL_CLK:                 rd_mux      = psel_clk_q;
      OFS_PSEL_DIN:                 rd_mux      = psel_din_q;
      OFS_MCLKCFG:                  rd_mux      = mclkcfg_q;
      OFS_SMP_PTR:                  rd_mux      = smp_ptr_q;
      OFS_SMP_CNT:                  rd_mux[15:0] = smp_cnt_q;
      default:                      rd_mux      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      readdata_q <= 32'h0000_0000;
    end else if (AVS_READ_I & ~ack_q) begin
      readdata_q <= rd_mux;
    end
  end

  // enable set and clear; a zero bit leaves the enable alone
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      inten_q <= 3'h0;
    end else if (wr_take && AVS_BYTEENABLE_I[0] && AVS_ADDRESS_I == OFS_INTEN_SET) begin
      inten_q <= inten_q | AVS_WRITEDATA_I[2:0];
    end else if (wr_take && AVS_BYTEENABLE_I[0] && AVS_ADDRESS_I == OFS_INTEN_CLR) begin
      inten_q <= inten_q & ~AVS_WRITEDATA_I[2:0];
    end
  end

  // sticky events, a read clears only what it reported, a new event wins
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      status_q <= 3'h0;
    end else if (rd_take && AVS_ADDRESS_I == OFS_EV_STATUS) begin
      status_q <= (status_q & ~readdata_q[2:0]) | ev_pulse;
    end else begin
      status_q <= status_q | ev_pulse;
    end
  end

  assign IRQ_O = |(status_q & inten_q);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      enable_q   <= 1'b0;
      clksel_q   <= CLK_SEL_DEFAULT;
      mode_q     <= MODE_STEREO;
      gain_l_q   <= GAIN_UNITY;
      gain_r_q   <= GAIN_UNITY;
      ratio_q    <= RATIO_SEL_64;
      psel_clk_q <= PSEL_RESET;
      psel_din_q <= PSEL_RESET;
      mclkcfg_q  <= 32'h0000_0000;
      smp_ptr_q  <= PTR_RESET;
      smp_cnt_q  <= CNT_RESET;
    end else if (wr_take && AVS_BYTEENABLE_I[0]) begin
      case (AVS_ADDRESS_I)
        OFS_ENABLE:  enable_q <= AVS_WRITEDATA_I[0];
        OFS_CLKCTRL: clksel_q <= AVS_WRITEDATA_I[0];
        OFS_MODE:    mode_q   <= AVS_WRITEDATA_I[0];
        OFS_RATIO:   ratio_q  <= AVS_WRITEDATA_I[0];
        OFS_GAIN_L:  gain_l_q <= (AVS_WRITEDATA_I[6:0] > GAIN_MAX) ? GAIN_MAX : AVS_WRITEDATA_I[6:0];
        OFS_GAIN_R:  gain_r_q <= (AVS_WRITEDATA_I[6:0] > GAIN_MAX) ? GAIN_MAX : AVS_WRITEDATA_I[6:0];
        default: begin
        end
      endcase
    end
    if (RST_N_I && wr_take) begin
      case (AVS_ADDRESS_I)
        OFS_PSEL_CLK: psel_clk_q <= be_merge(psel_clk_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        OFS_PSEL_DIN: psel_din_q <= be_merge(psel_din_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        OFS_MCLKCFG:  mclkcfg_q  <= be_merge(mclkcfg_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        OFS_SMP_PTR:  smp_ptr_q  <= be_merge(smp_ptr_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        OFS_SMP_CNT:  smp_cnt_q  <= 16'(be_merge({16'h0000, smp_cnt_q}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // microphone clock and decimation
  logic       [4:0]  div_q;
  logic       [4:0]  half_last;
  logic              mic_clk_q;
  logic              din_s1_q;
  logic              din_s2_q;
  logic              toggle;
  logic       [6:0]  bit_cnt_q;
  logic       [6:0]  ratio_last;
  logic       [6:0]  acc_l_q;
  logic       [6:0]  acc_r_q;
  logic       [6:0]  acc_l_full;
  logic       [6:0]  acc_r_full;
  logic              frame_done;
  logic signed [15:0] pcm_l;
  logic signed [15:0] pcm_r;

  assign half_last  = ((clksel_q == CLK_SEL_1280K) ? HALF_1280K : HALF_DEFAULT) - 5'h01;
  assign ratio_last = ((ratio_q == RATIO_SEL_80) ? RATIO_80 : RATIO_64) - 7'h01;
  assign toggle     = enable_q && (div_q == half_last);
  assign MIC_CLK_O    = mic_clk_q;
  assign MIC_CLK_OE_O = enable_q & ~psel_clk_q[PSEL_DISC_BIT];

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= MIC_DATA_I;
      din_s2_q <= din_s1_q;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !enable_q) begin
      div_q     <= 5'h00;
      mic_clk_q <= 1'b0;
    end else if (toggle) begin
      div_q     <= 5'h00;
      mic_clk_q <= ~mic_clk_q;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // left bit taken before the rising edge, right bit before the falling edge
  assign acc_l_full = acc_l_q + 7'(din_s2_q & ~mic_clk_q);
  assign acc_r_full = acc_r_q + 7'(din_s2_q & mic_clk_q);
  assign frame_done = toggle && mic_clk_q && (bit_cnt_q == ratio_last);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !enable_q) begin
      bit_cnt_q <= 7'h00;
      acc_l_q   <= 7'h00;
      acc_r_q   <= 7'h00;
    end else if (frame_done) begin
      bit_cnt_q <= 7'h00;
      acc_l_q   <= 7'h00;
      acc_r_q   <= 7'h00;
    end else if (toggle) begin
      acc_l_q <= acc_l_full;
      acc_r_q <= acc_r_full;
      if (mic_clk_q) begin
        bit_cnt_q <= bit_cnt_q + 7'h01;
      end
    end
  end

  assign pcm_l = ($signed({9'h000, acc_l_full}) - $signed({9'h000, 7'(ratio_last >> 1) + 7'h01})) <<< PCM_SHIFT;
  assign pcm_r = ($signed({9'h000, acc_r_full}) - $signed({9'h000, 7'(ratio_last >> 1) + 7'h01})) <<< PCM_SHIFT;

  logic signed [15:0] out_l;
  logic signed [15:0] out_r;
  assign out_l = gain_apply(pcm_l, gain_l_q);
  assign out_r = gain_apply((mode_q == MODE_MONO) ? pcm_l : pcm_r, gain_r_q);

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencing and sample writes
  pdmr_state_t state_q;
  logic [15:0] remaining_q;
  logic [15:0] per_word;
  logic        dma_fire;
  logic        start_req;
  logic        stop_req;
  logic        last_word;

  assign start_req = wr_take && AVS_ADDRESS_I == OFS_TASK_START && AVS_WRITEDATA_I[0] && AVS_BYTEENABLE_I[0];
  assign stop_req  = wr_take && AVS_ADDRESS_I == OFS_TASK_STOP && AVS_WRITEDATA_I[0] && AVS_BYTEENABLE_I[0];
  assign per_word  = (mode_q == MODE_MONO) ? 16'h0001 : 16'h0002;
  assign dma_fire  = DMA_VALID_O & DMA_READY_I;
  assign last_word = remaining_q <= per_word;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:     state_q <= (start_req && enable_q) ? ST_RUN : ST_IDLE;
        ST_RUN:      state_q <= (stop_req || !enable_q) ? ST_STOPPING : ST_RUN;
        ST_STOPPING: state_q <= (!DMA_VALID_O || dma_fire) ? ST_IDLE : ST_STOPPING;
        default:     state_q <= ST_IDLE;
      endcase
    end
  end

  // buffer position; registers are reloaded at each buffer end
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      DMA_ADDR_O  <= 32'h0000_0000;
      remaining_q <= 16'h0000;
    end else if ((state_q == ST_IDLE && start_req) || (dma_fire && last_word)) begin
      DMA_ADDR_O  <= smp_ptr_q;
      remaining_q <= smp_cnt_q;
    end else if (dma_fire) begin
      DMA_ADDR_O  <= DMA_ADDR_O + 32'h0000_0004;
      remaining_q <= remaining_q - per_word;
    end
  end

  // a frame arriving while the previous word is unaccepted is dropped
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      DMA_VALID_O <= 1'b0;
      DMA_DATA_O  <= 32'h0000_0000;
    end else if (state_q == ST_RUN && frame_done && (!DMA_VALID_O || dma_fire)) begin
      DMA_VALID_O <= 1'b1;
      DMA_DATA_O  <= (mode_q == MODE_MONO) ? {16'h0000, out_l} : {out_r, out_l};
    end else if (dma_fire) begin
      DMA_VALID_O <= 1'b0;
    end
  end

  always_comb begin
    ev_pulse              = 3'h0;
    ev_pulse[EV_STARTED]  = state_q == ST_IDLE && start_req && enable_q;
    ev_pulse[EV_HALTED]   = state_q == ST_STOPPING && (!DMA_VALID_O || dma_fire);
    ev_pulse[EV_DONE]     = (dma_fire && last_word) || ev_pulse[EV_HALTED];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence clr_write(int b);
    wr_take && AVS_ADDRESS_I == OFS_INTEN_CLR && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[b];
  endsequence

  sequence clr_zero_write;
    wr_take && AVS_ADDRESS_I == OFS_INTEN_CLR && !AVS_WRITEDATA_I[EV_STARTED];
  endsequence

  AST_CLR_STARTED: assert property (clr_write(EV_STARTED) |=> !inten_q[EV_STARTED])
    else $error("start enable not cleared");
  AST_CLR_HALTED: assert property (clr_write(EV_HALTED) |=> !inten_q[EV_HALTED])
    else $error("halt enable not cleared");
  AST_CLR_DONE: assert property (clr_write(EV_DONE) |=> !inten_q[EV_DONE])
    else $error("end enable not cleared");
  AST_CLR_ZERO: assert property (clr_zero_write |=> inten_q[EV_STARTED] == $past(inten_q[EV_STARTED]))
    else $error("zero write changed enable");
  AST_GAIN_RANGE: assert property (gain_l_q <= GAIN_MAX && gain_r_q <= GAIN_MAX)
    else $error("gain code beyond range");
  AST_GAIN_UNITY_L: assert property (frame_done && gain_l_q == GAIN_UNITY |-> out_l == pcm_l)
    else $error("unity left gain altered sample");
  AST_GAIN_UNITY_R: assert property (frame_done && gain_r_q == GAIN_UNITY && mode_q == MODE_STEREO
                                     |-> out_r == pcm_r)
    else $error("unity right gain altered sample");
  AST_FRAME_LEN: assert property (frame_done |-> bit_cnt_q == ((ratio_q == RATIO_SEL_80) ? 7'h4f : 7'h3f))
    else $error("frame length does not match ratio");
  AST_CLK_HALF: assert property (disable iff (!RST_N_I || !enable_q)
    $rose(mic_clk_q) && clksel_q == CLK_SEL_DEFAULT && $stable(clksel_q)
      |-> mic_clk_q [*8] ##1 mic_clk_q ##1 mic_clk_q ##1 !mic_clk_q)
    else $error("default mic clock half period wrong");
  AST_MONO_ROUTE: assert property (DMA_VALID_O && mode_q == MODE_MONO && $rose(DMA_VALID_O)
                                   |-> DMA_DATA_O[31:16] == 16'h0000)
    else $error("mono word carries right data");
  AST_START_PTR: assert property (state_q == ST_IDLE && start_req |=> DMA_ADDR_O == $past(smp_ptr_q))
    else $error("pointer not loaded at start");
  AST_END_EVENT: assert property (dma_fire && last_word |=> status_q[EV_DONE])
    else $error("end event missing after last sample");

endmodule // pdmr_top

// ---- bench/pdmr_mic_model.sv ----
module pdmr_mic_model (
  input  wire logic clock_i,
  input  wire logic mic_clk_i,
  input  wire logic mic_clk_oe_i,
  output logic      mic_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mic_clk_prev;
  initial begin
    mic_data_o   = 1'b0;
    mic_clk_prev = 1'b0;
  end
  // left bit settles after falling edge, right bit after rising edge
  always @(posedge clock_i) begin
    mic_clk_prev <= mic_clk_i;
    if (mic_clk_oe_i !== 1'b1)
      mic_data_o <= ~mic_data_o;
    else if (mic_clk_i && !mic_clk_prev)
      mic_data_o <= 1'b0;
    else if (!mic_clk_i && mic_clk_prev)
      mic_data_o <= 1'b1;
  end
endmodule // pdmr_mic_model

// ---- bench/test_pdmr_top.sv ----
module test_pdmr_top;
  import pdmr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK_I, RST_N_I, AVS_READ_I, AVS_WRITE_I, IRQ_O, MIC_CLK_O, MIC_CLK_OE_O, MIC_DATA_I;
  logic [11:0] AVS_ADDRESS_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, DMA_ADDR_O, DMA_DATA_O;
  logic [3:0]  AVS_BYTEENABLE_I;
  logic        AVS_WAITREQUEST_O, DMA_VALID_O, DMA_READY_I;
  int          errors, tests_run, cycles;
  localparam logic [11:0] RW_OFS [8] = '{OFS_RATIO, OFS_MODE, OFS_CLKCTRL, OFS_SMP_PTR,
                                         OFS_SMP_CNT, OFS_MCLKCFG, OFS_GAIN_L, OFS_GAIN_R};
  localparam logic [31:0] RW_EXP [8] = '{32'h1, 32'h1, 32'h1, 32'hffff_ffff,
                                         32'hffff, 32'hffff_ffff, 32'h50, 32'h50};
  pdmr_top u_pdmr_top (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .IRQ_O(IRQ_O), .MIC_CLK_O(MIC_CLK_O),
    .MIC_CLK_OE_O(MIC_CLK_OE_O), .MIC_DATA_I(MIC_DATA_I), .DMA_VALID_O(DMA_VALID_O),
    .DMA_ADDR_O(DMA_ADDR_O), .DMA_DATA_O(DMA_DATA_O), .DMA_READY_I(DMA_READY_I));
  pdmr_mic_model u_pdmr_mic_model (.clock_i(CLOCK_I), .mic_clk_i(MIC_CLK_O),
    .mic_clk_oe_i(MIC_CLK_OE_O), .mic_data_o(MIC_DATA_I));
  initial begin
    CLOCK_I = 1'b0;
    forever #25 CLOCK_I = ~CLOCK_I;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge CLOCK_I) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    AVS_ADDRESS_I   <= a;
    AVS_WRITEDATA_I <= d;
    AVS_WRITE_I     <= 1'b1;
    do @(posedge CLOCK_I); while (AVS_WAITREQUEST_O !== 1'b0);
    AVS_WRITE_I <= 1'b0;
  endtask
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge CLOCK_I);
    AVS_ADDRESS_I <= a;
    AVS_READ_I    <= 1'b1;
    do @(posedge CLOCK_I); while (AVS_WAITREQUEST_O !== 1'b0);
    d = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    logic [31:0] rd;
    logic [11:0] ofs [5] = '{OFS_GAIN_L, OFS_GAIN_R, OFS_INTEN_CLR, OFS_PSEL_CLK, 12'h600};
    logic [31:0] exp [5] = '{32'h28, 32'h28, 32'h0, 32'h8000_0000, 32'h0};
    check("clock enable at reset", MIC_CLK_OE_O, 0);
    for (int i = 0; i < 5; i++) begin
      bus_read(ofs[i], rd);
      check("reset value", rd, exp[i]);
    end
  endtask
  task automatic irq_enables;
    logic [31:0] rd;
    bus_write(OFS_INTEN_SET, 32'h7);
    bus_read(OFS_INTEN_CLR, rd);
    check("enables after set", rd, 32'h7);
    bus_write(OFS_INTEN_CLR, 32'h0);
    bus_read(OFS_INTEN_CLR, rd);
    check("enables after zero write", rd, 32'h7);
    for (int i = 0; i < 3; i++) begin
      bus_write(OFS_INTEN_CLR, 32'h1 << i);
      bus_read(OFS_INTEN_CLR, rd);
      check("enables after disable", rd, 32'h7 & ~((32'h2 << i) - 1));
    end
  endtask
  task automatic reg_access;
    logic [31:0] rd;
    for (int i = 0; i < 8; i++) begin
      bus_write(RW_OFS[i], 32'hffff_ffff);
      bus_read(RW_OFS[i], rd);
      check("register ones", rd, RW_EXP[i]);
      bus_write(RW_OFS[i], 32'h0);
      bus_read(RW_OFS[i], rd);
      check("register zeros", rd, 32'h0);
    end
    bus_write(12'h600, 32'h1234_5678);
    bus_read(12'h600, rd);
    check("unmapped read", rd, 32'h0);
    bus_write(OFS_GAIN_L, 32'h28);
    bus_write(OFS_GAIN_R, 32'h28);
  endtask
  // sink stalls every word; buffer of four samples, three words taken
  task automatic run_stream(input logic mono, input logic r80, input logic [6:0] gl,
                            input logic irq_en, input logic exact, input logic [31:0] exp_w);
    logic [31:0] rd, acc, w1, a0;
    int          n, half, wpb;
    logic        bad;
    wpb = mono ? 4 : 2;
    bus_write(OFS_PSEL_CLK, 32'h0);
    bus_write(OFS_PSEL_DIN, 32'h0);
    bus_write(OFS_RATIO, {31'h0, r80});
    bus_write(OFS_CLKCTRL, {31'h0, r80});
    bus_write(OFS_MODE, {31'h0, mono});
    bus_write(OFS_GAIN_L, {25'h0, gl});
    bus_write(OFS_SMP_PTR, 32'h2000_0100);
    bus_write(OFS_SMP_CNT, 32'h4);
    bus_write(irq_en ? OFS_INTEN_SET : OFS_INTEN_CLR, 32'h4);
    bus_write(OFS_ENABLE, 32'h1);
    n = 0;
    while (MIC_CLK_O !== 1'b1 && n < 100) begin
      @(posedge CLOCK_I);
      n++;
    end
    half = 0;
    while (MIC_CLK_O === 1'b1 && half < 100) begin
      @(posedge CLOCK_I);
      half++;
    end
    check("mic clock half period", half, r80 ? 8 : 10);
    check("mic clock enable", MIC_CLK_OE_O, 1);
    bus_write(OFS_TASK_START, 32'h1);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (DMA_VALID_O !== 1'b1 && n < 3000) begin
        @(posedge CLOCK_I);
        n++;
      end
      a0  = DMA_ADDR_O;
      bad = 1'b0;
      for (int i = 0; i < 20; i++) begin
        @(posedge CLOCK_I);
        if (DMA_VALID_O !== 1'b1 || DMA_ADDR_O !== a0)
          bad = 1'b1;
      end
      check("word held while stalled", bad, 0);
      check("word address", a0, 32'h2000_0100 + 4 * (k % wpb));
      DMA_READY_I <= 1'b1;
      @(posedge CLOCK_I);
      if (k == 1)
        w1 = DMA_DATA_O;
      DMA_READY_I <= 1'b0;
      @(posedge CLOCK_I);
    end
    if (exact)
      check("sample word", w1, exp_w);
    else
      check("attenuated left", (w1[15:0] > 0 && w1[15:0] < 16'h4000 && w1[31:16] == 0), 1);
    check("interrupt line", IRQ_O, irq_en && wpb == 2);
    bus_read(OFS_EV_STATUS, rd);
    check("event status", rd, wpb == 2 ? 32'h5 : 32'h1);
    @(posedge CLOCK_I);
    check("interrupt after read", IRQ_O, 0);
    bus_write(OFS_TASK_STOP, 32'h1);
    DMA_READY_I <= 1'b1;
    acc = 0;
    n   = 0;
    while (acc[1] !== 1'b1 && n < 1000) begin
      bus_read(OFS_EV_STATUS, rd);
      acc = acc | rd;
      n++;
    end
    check("halt and end after stop", acc[2:1], 2'b11);
    DMA_READY_I <= 1'b0;
    bus_write(OFS_ENABLE, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RST_N_I          = 1'b0;
    AVS_READ_I       = 1'b0;
    AVS_WRITE_I      = 1'b0;
    AVS_ADDRESS_I    = 12'h000;
    AVS_WRITEDATA_I  = 32'h0;
    AVS_BYTEENABLE_I = 4'hf;
    DMA_READY_I      = 1'b0;
    errors           = 0;
    tests_run        = 0;
    cycles           = 0;
    repeat (16) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    reset_values();
    irq_enables();
    reg_access();
    run_stream(1'b0, 1'b0, 7'h28, 1'b1, 1'b1, 32'hc000_4000);
    run_stream(1'b0, 1'b1, 7'h28, 1'b0, 1'b1, 32'hb000_5000);
    run_stream(1'b1, 1'b0, 7'h00, 1'b1, 1'b0, 32'h0);
    tally_and_finish();
  end
endmodule // test_pdmr_top
